// ===== rtl/inrush_harmonic_detector.sv
// three-phase second-harmonic inrush detector with avalon-mm registers
// ********************
// Operation
// - flag when harm2/fund exceeds ratio setting
// - flag low unless fund above minimum level
// - each phase judged from its own inputs
// - general flag is OR of phases
// - block input forces all flags low
// - ratio setting 5..50 percent, default 15
// - minimum level 20..100 percent, default 30
// - on/off events at general flag edges
// ********************
`timescale 1ns/10ps
module inrush_harmonic_detector (
  input wire logic clk,
  input wire logic rst,
  input wire inrush_pkg::avl_req_t avlReq,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire inrush_pkg::phase_meas_t [2:0] meas,
  input wire logic measValid,
  input wire logic detectorBlockIn,
  output logic phaseAInrushFlag,
  output logic phaseBInrushFlag,
  output logic phaseCInrushFlag,
  output logic generalInrushFlag,
  output logic inrushOnEvent,
  output logic inrushOffEvent,
  output logic irq
);
  import inrush_pkg::*;

  // ********************
  // helpers
  // ********************
  function automatic logic [PCT_W-1:0] clampPct(input logic [7:0] v,
      input logic [PCT_W-1:0] lo, input logic [PCT_W-1:0] hi);
    logic [PCT_W-1:0] r;
    if (v < {1'b0, lo}) begin
      r = lo;
    end else if (v > {1'b0, hi}) begin
      r = hi;
    end else begin
      r = v[PCT_W-1:0];
    end
    return r;
  endfunction

  function automatic logic [PROD_W-1:0] mulPct(input logic [MAG_W-1:0] m,
      input logic [PCT_W-1:0] p);
    return PROD_W'(m * p);
  endfunction

  // ********************
  // avalon slave: one wait cycle per access
  // ********************
  logic ackQ;
  logic [31:0] readdataQ;
  logic operQ;
  logic [PCT_W-1:0] ratioQ;
  logic [PCT_W-1:0] minLvlQ;
  logic [MAG_W-1:0] nominalQ;
  logic [IRQ_W-1:0] irqStatQ;
  logic [IRQ_W-1:0] irqMaskQ;
  logic [2:0] phaseFlagQ;
  logic generalQ;
  logic onEvQ;
  logic offEvQ;
  logic request;
  logic wrTake;
  logic [31:0] rdMux;

  assign request = avlReq.read | avlReq.write;
  assign waitrequest = request & ~ackQ;
  assign wrTake = avlReq.write & ackQ;
  assign readdata = readdataQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      ackQ <= 1'b0;
    end else begin
      ackQ <= request & ~ackQ;
    end
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    case (avlReq.address)
      OFS_CTRL: rdMux[CTRL_OPER_BIT] = operQ;
      OFS_RATIO: rdMux[PCT_W-1:0] = ratioQ;
      OFS_MINLVL: rdMux[PCT_W-1:0] = minLvlQ;
      OFS_NOMINAL: rdMux[MAG_W-1:0] = nominalQ;
      OFS_FLAGS: rdMux[FLAG_GEN_BIT:0] = {generalQ, phaseFlagQ};
      OFS_IRQSTAT: rdMux[IRQ_W-1:0] = irqStatQ;
      OFS_IRQMASK: rdMux[IRQ_W-1:0] = irqMaskQ;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, stands at the release edge
  always_ff @(posedge clk) begin
    if (rst) begin
      readdataQ <= 32'h0000_0000;
    end else if (avlReq.read & ~ackQ) begin
      readdataQ <= rdMux;
    end
  end

  // ********************
  // settings registers
  // ********************
  always_ff @(posedge clk) begin
    if (rst) begin
      operQ <= CTRL_OPER_RST;
      ratioQ <= RATIO_RST;
      minLvlQ <= MINLVL_RST;
      nominalQ <= NOMINAL_RST;
      irqMaskQ <= '0;
    end else if (wrTake) begin
      case (avlReq.address)
        OFS_CTRL: begin
          if (avlReq.byteenable[0]) begin
            operQ <= avlReq.writedata[CTRL_OPER_BIT];
          end
        end
        OFS_RATIO: begin
          // out-of-range writes saturate rather than fault
          if (avlReq.byteenable[0]) begin
            ratioQ <= clampPct(avlReq.writedata[7:0], RATIO_MIN, RATIO_MAX);
          end
        end
        OFS_MINLVL: begin
          if (avlReq.byteenable[0]) begin
            minLvlQ <= clampPct(avlReq.writedata[7:0], MINLVL_MIN, MINLVL_MAX);
          end
        end
        OFS_NOMINAL: begin
          if (avlReq.byteenable[0]) begin
            nominalQ[7:0] <= avlReq.writedata[7:0];
          end
          if (avlReq.byteenable[1]) begin
            nominalQ[15:8] <= avlReq.writedata[15:8];
          end
        end
        OFS_IRQMASK: begin
          if (avlReq.byteenable[0]) begin
            irqMaskQ <= avlReq.writedata[IRQ_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ********************
  // detection
  // ********************
  logic [2:0] phaseHit;
  logic [PROD_W-1:0] minThresh;
  logic disabled;

  assign disabled = detectorBlockIn | ~operQ;
  // minimum level as absolute magnitude scaled by 100
  assign minThresh = mulPct(nominalQ, minLvlQ);

  // ratio compared by products so no divider is needed
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      phaseHit[p] = (mulPct(meas[p].harm2, PCT_100) > mulPct(meas[p].fund, ratioQ))
        && (mulPct(meas[p].fund, PCT_100) > minThresh);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phaseFlagQ <= 3'h0;
    end else if (disabled) begin
      phaseFlagQ <= 3'h0;
    end else if (measValid) begin
      phaseFlagQ <= phaseHit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      generalQ <= 1'b0;
    end else if (disabled) begin
      generalQ <= 1'b0;
    end else if (measValid) begin
      generalQ <= |phaseHit;
    end
  end

  assign phaseAInrushFlag = phaseFlagQ[0];
  assign phaseBInrushFlag = phaseFlagQ[1];
  assign phaseCInrushFlag = phaseFlagQ[2];
  assign generalInrushFlag = generalQ;

  // ********************
  // events and interrupt
  // ********************
  logic generalDlyQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      generalDlyQ <= 1'b0;
      onEvQ <= 1'b0;
      offEvQ <= 1'b0;
    end else begin
      generalDlyQ <= generalQ;
      onEvQ <= generalQ & ~generalDlyQ;
      offEvQ <= ~generalQ & generalDlyQ;
    end
  end

  assign inrushOnEvent = onEvQ;
  assign inrushOffEvent = offEvQ;

  // a new event in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatQ <= '0;
    end else begin
      for (int b = 0; b < IRQ_W; b++) begin
        if ((b == IRQ_ON_BIT) ? onEvQ : offEvQ) begin
          irqStatQ[b] <= 1'b1;
        end else if (wrTake && avlReq.address == OFS_IRQSTAT && avlReq.byteenable[0]
            && avlReq.writedata[b]) begin
          irqStatQ[b] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irqStatQ & irqMaskQ);

  // ********************
  // assertions
  // ********************
  sequence seqBusReq;
    request & ~ackQ;
  endsequence

  sequence seqBusDone;
    ##1 (request & ~waitrequest);
  endsequence

  property propBusAnswer;
    @(posedge clk) disable iff (rst) seqBusReq |-> seqBusDone;
  endproperty

  AST_BUS_ONE_WAIT: assert property (propBusAnswer)
    else $error("access not answered after exactly one wait cycle");

  AST_BLOCK_CLEARS: assert property (
    @(posedge clk) disable iff (rst) detectorBlockIn |=> (phaseFlagQ == 3'h0) && !generalQ)
    else $error("flags active after block input");

  AST_GENERAL_OR: assert property (
    @(posedge clk) disable iff (rst) generalQ == (|phaseFlagQ))
    else $error("general flag differs from phase OR");

  AST_RATIO_RANGE: assert property (
    @(posedge clk) disable iff (rst) ratioQ >= RATIO_MIN && ratioQ <= RATIO_MAX)
    else $error("ratio setting out of range");

  AST_MINLVL_RANGE: assert property (
    @(posedge clk) disable iff (rst) minLvlQ >= MINLVL_MIN && minLvlQ <= MINLVL_MAX)
    else $error("minimum level out of range");

  AST_LOW_FUND: assert property (
    @(posedge clk) disable iff (rst)
      measValid && mulPct(meas[0].fund, PCT_100) <= minThresh |=> !phaseFlagQ[0])
    else $error("phase A flagged below minimum fundamental");

  AST_RATIO_HIT: assert property (
    @(posedge clk) disable iff (rst) measValid && !disabled && phaseHit[1]
      |=> phaseFlagQ[1])
    else $error("phase B missed a ratio hit");

  AST_HOLD_NO_STROBE: assert property (
    @(posedge clk) disable iff (rst) !measValid && !disabled |=> $stable(phaseFlagQ))
    else $error("flags changed without a sample strobe");

  AST_ON_EVENT: assert property (
    @(posedge clk) disable iff (rst) $rose(generalQ) |=> inrushOnEvent ##1 !inrushOnEvent)
    else $error("on event missing at general rise");

  AST_OFF_EVENT: assert property (
    @(posedge clk) disable iff (rst) $fell(generalQ) |=> inrushOffEvent && !inrushOnEvent)
    else $error("off event missing at general fall");

  AST_IRQ_STICKY: assert property (
    @(posedge clk) disable iff (rst) inrushOnEvent |=> irqStatQ[IRQ_ON_BIT])
    else $error("on event did not set status");

  AST_OFF_STICKY: assert property (
    @(posedge clk) disable iff (rst) inrushOffEvent |=> irqStatQ[IRQ_OFF_BIT])
    else $error("off event did not set status");

  AST_OPER_OFF: assert property (
    @(posedge clk) disable iff (rst) !operQ |=> (phaseFlagQ == 3'h0) && !generalQ)
    else $error("flags active while operation is off");
endmodule

// ===== rtl/inrush_pkg.sv
// constants, register map and carrier types of the inrush detector
package inrush_pkg;
  // ********************
  // data widths
  // ********************
  localparam int MAG_W = 16;
  localparam int PCT_W = 7;
  localparam int PROD_W = MAG_W + PCT_W;
  localparam int ADDR_W = 5;
  localparam logic [PCT_W-1:0] PCT_100 = 7'h64;

  // ********************
  // register byte offsets
  // ********************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_RATIO = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_MINLVL = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_NOMINAL = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQSTAT = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQMASK = 5'h18;

  // ********************
  // field positions
  // ********************
  localparam int CTRL_OPER_BIT = 0;
  localparam int FLAG_GEN_BIT = 3;
  localparam int IRQ_ON_BIT = 0;
  localparam int IRQ_OFF_BIT = 1;
  localparam int IRQ_W = 2;

  // ********************
  // settings: reset values and ranges
  // ********************
  localparam logic [PCT_W-1:0] RATIO_MIN = 7'h05;
  localparam logic [PCT_W-1:0] RATIO_MAX = 7'h32;
  localparam logic [PCT_W-1:0] RATIO_RST = 7'h0F;
  localparam logic [PCT_W-1:0] MINLVL_MIN = 7'h14;
  localparam logic [PCT_W-1:0] MINLVL_MAX = 7'h64;
  localparam logic [PCT_W-1:0] MINLVL_RST = 7'h1E;
  localparam logic [MAG_W-1:0] NOMINAL_RST = 16'h03E8;
  localparam logic CTRL_OPER_RST = 1'b0;

  // ********************
  // carriers
  // ********************
  typedef struct packed {
    logic [MAG_W-1:0] fund;
    logic [MAG_W-1:0] harm2;
  } phase_meas_t;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avl_req_t;

  typedef struct packed {
    logic phaseA;
    logic phaseB;
    logic phaseC;
    logic general;
  } inrush_flags_t;
endpackage

// ===== testbench/harmonic_source_model.sv
// upstream harmonic analysis stage model feeding fund and harm2 per phase
`timescale 1ns/10ps
module harmonic_source_model (
  input wire logic clk,
  input wire inrush_pkg::phase_meas_t [2:0] sample,
  input wire logic fire,
  output inrush_pkg::phase_meas_t [2:0] meas,
  output logic measValid
);
  import inrush_pkg::*;
  // off-strobe data flips every cycle so a stray read cannot match by luck
  always_ff @(posedge clk) begin
    measValid <= fire;
    meas <= fire ? sample : ~meas;
  end
endmodule

// ===== testbench/inrush_harmonic_detector_bench.sv
// self-checking bench of the inrush detector
`timescale 1ns/10ps
module inrush_harmonic_detector_bench;
  import inrush_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  avl_req_t avlReq = '0;
  logic [31:0] readdata;
  logic waitrequest;
  phase_meas_t [2:0] meas;
  phase_meas_t [2:0] sample = '0;
  phase_meas_t [2:0] s;
  phase_meas_t [2:0] hit;
  logic measValid;
  logic fire = 1'b0;
  logic blk = 1'b0;
  logic fa, fb, fc, fg, onEv, offEv, irq;
  logic [6:0] ratio;
  logic [6:0] lvl;
  int err_total = 0;
  int num_checks = 0;
  int onCnt = 0;
  int offCnt = 0;
  int base;
  wire [3:0] flags = {fg, fc, fb, fa};

  always #2.5 clk = ~clk;

  harmonic_source_model src (.clk(clk), .sample(sample), .fire(fire), .meas(meas),
    .measValid(measValid));
  inrush_harmonic_detector dut (.clk(clk), .rst(rst), .avlReq(avlReq), .readdata(readdata),
    .waitrequest(waitrequest), .meas(meas), .measValid(measValid), .detectorBlockIn(blk),
    .phaseAInrushFlag(fa), .phaseBInrushFlag(fb), .phaseCInrushFlag(fc),
    .generalInrushFlag(fg), .inrushOnEvent(onEv), .inrushOffEvent(offEv), .irq(irq));

  // event pulses last one cycle, so they are counted at every edge
  always @(posedge clk) begin
    if (onEv === 1'b1) onCnt++;
    if (offEv === 1'b1) offCnt++;
  end

  // ********************
  // helpers
  // ********************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  // waitrequest and readdata are read before this edge's updates land
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] r);
    @(posedge clk);
    avlReq.address <= a;
    avlReq.write <= w;
    avlReq.read <= !w;
    avlReq.writedata <= d;
    avlReq.byteenable <= 4'hF;
    do @(posedge clk); while (waitrequest !== 1'b0);
    r = readdata;
    avlReq.read <= 1'b0;
    avlReq.write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(nm, r, exp);
  endtask

  task automatic strobe(input phase_meas_t [2:0] v);
    @(posedge clk);
    sample <= v;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  function automatic logic [31:0] expFlags(phase_meas_t [2:0] v, logic [6:0] r, logic [6:0] m);
    logic [2:0] e;
    for (int i = 0; i < 3; i++) begin
      e[i] = (32'(v[i].harm2) * 100 > 32'(v[i].fund) * r) &&
        (32'(v[i].fund) * 100 > 32'(NOMINAL_RST) * m);
    end
    return {28'h0, |e, e};
  endfunction

  initial begin
    #200000;
    err_total++;
    end_sim();
  end

  // ********************
  // tests
  // ********************
  initial begin
    void'($urandom(94));
    hit = '0;
    hit[0] = {16'h03E8, 16'h01F4};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdchk("ratio", OFS_RATIO, 32'(RATIO_RST));
    rdchk("minlvl", OFS_MINLVL, 32'(MINLVL_RST));
    rdchk("nominal", OFS_NOMINAL, 32'(NOMINAL_RST));
    rdchk("unmapped", 5'h1C, 32'h0);
    wr(OFS_RATIO, 32'h7F);
    rdchk("ratio hi", OFS_RATIO, 32'(RATIO_MAX));
    wr(OFS_RATIO, 32'h02);
    rdchk("ratio lo", OFS_RATIO, 32'(RATIO_MIN));
    wr(OFS_MINLVL, 32'h7F);
    rdchk("minlvl hi", OFS_MINLVL, 32'(MINLVL_MAX));
    wr(OFS_MINLVL, 32'h10);
    rdchk("minlvl lo", OFS_MINLVL, 32'(MINLVL_MIN));
    $display("test settings done");
    wr(OFS_RATIO, 32'h0F);
    wr(OFS_MINLVL, 32'h1E);
    wr(OFS_CTRL, 32'h1);
    rdchk("ctrl", OFS_CTRL, 32'h00000001);
    // ratio exactly at setting, just above, and fund exactly at minimum
    s[0] = {16'h03E8, 16'h0096};
    s[1] = {16'h03E8, 16'h0097};
    s[2] = {16'h012C, 16'h0FFF};
    strobe(s);
    chk("corner", 32'(flags), 32'h0000000A);
    for (int k = 0; k < 120; k++) begin
      if (k % 12 == 0) begin
        ratio = 7'($urandom_range(5, 50));
        lvl = 7'($urandom_range(20, 100));
        wr(OFS_RATIO, 32'(ratio));
        wr(OFS_MINLVL, 32'(lvl));
      end
      for (int i = 0; i < 3; i++) begin
        s[i].fund = 16'($urandom_range(100, 3000));
        s[i].harm2 = 16'(32'(s[i].fund) * ratio / 100 + $urandom_range(0, 4) - 2);
      end
      strobe(s);
      chk("flags", 32'(flags), expFlags(s, ratio, lvl));
    end
    $display("test ratio done");
    wr(OFS_RATIO, 32'h0F);
    wr(OFS_MINLVL, 32'h1E);
    wr(OFS_IRQMASK, 32'h3);
    rdchk("mask", OFS_IRQMASK, 32'h00000003);
    strobe('0);
    wr(OFS_IRQSTAT, 32'h3);
    rdchk("stat clr", OFS_IRQSTAT, 32'h0);
    base = onCnt;
    strobe(hit);
    chk("on ev", onCnt - base, 1);
    rdchk("stat on", OFS_IRQSTAT, 32'h1);
    chk("irq on", 32'(irq), 32'h1);
    wr(OFS_IRQSTAT, 32'h1);
    @(posedge clk);
    chk("irq clr", 32'(irq), 32'h0);
    base = offCnt;
    strobe('0);
    chk("off ev", offCnt - base, 1);
    rdchk("stat off", OFS_IRQSTAT, 32'h2);
    wr(OFS_IRQMASK, 32'h0);
    @(posedge clk);
    chk("irq mask", 32'(irq), 32'h0);
    $display("test events done");
    strobe(hit);
    chk("pre blk", 32'(flags), 32'h00000009);
    rdchk("flags reg", OFS_FLAGS, 32'h00000009);
    blk <= 1'b1;
    repeat (3) @(posedge clk);
    chk("blk", 32'(flags), 32'h0);
    strobe(hit);
    chk("blk strobe", 32'(flags), 32'h0);
    blk <= 1'b0;
    strobe(hit);
    chk("unblk", 32'(flags), 32'h00000009);
    $display("test block done");
    // doubling nominal lifts the minimum so a 500 fundamental no longer counts
    wr(OFS_NOMINAL, 32'h000007D0);
    rdchk("nominal wr", OFS_NOMINAL, 32'h000007D0);
    s = hit;
    s[0].fund = 16'h01F4;
    strobe(s);
    chk("nominal lvl", 32'(flags), 32'h0);
    strobe(hit);
    chk("nominal hit", 32'(flags), 32'h00000009);
    wr(OFS_CTRL, 32'h0);
    strobe(hit);
    chk("oper off", 32'(flags), 32'h0);
    $display("test nominal done");
    end_sim();
  end
endmodule
